// File: design/cmc_pkg.sv
// constants and types shared by the configuration memory crc checker
package cmc_pkg;
  // clock rates in kHz; the check rate is derived from the core clock
  localparam int unsigned CMC_CLK_KHZ = 200000;
  localparam int unsigned CMC_OSC_KHZ = 80000;
  localparam int unsigned CMC_MIN_KHZ_X10 = 3125;
  localparam logic [18:0] CMC_ACC_STEP = 19'(CMC_OSC_KHZ);
  localparam logic [18:0] CMC_ACC_WRAP = 19'(CMC_CLK_KHZ);
  localparam logic [3:0] CMC_DIV_EXP_MAX = 4'h8;
  // configuration memory shape
  localparam int CMC_AW = 6;
  localparam int CMC_DEPTH = 64;
  localparam int CMC_DW = 32;
  localparam logic [CMC_AW-1:0] CMC_LAST_ADDR = 6'h3f;
  // crc generators and seeds
  localparam logic [31:0] CMC_CRC32_POLY = 32'h04c11db7;
  localparam logic [31:0] CMC_CRC32_INIT = 32'hffffffff;
  localparam logic [15:0] CMC_CRC16_POLY = 16'h8005;
  localparam logic [15:0] CMC_CRC16_INIT = 16'hffff;
  // reset values
  localparam logic [31:0] CMC_SIG_RST = 32'h00000000;
  localparam logic [31:0] CMC_STORE_RST = 32'h00000000;
  // test port instruction that opens the storage register scan chain
  localparam int CMC_IR_W = 10;
  localparam logic [CMC_IR_W-1:0] CMC_SCAN_INSTR = 10'h015;
  // synchronised pin vector layout
  localparam int CMC_PIN_TCK = 0;
  localparam int CMC_PIN_TDI = 1;
  localparam int CMC_PIN_SHIFT = 2;
  localparam int CMC_PIN_IR = 3;
  localparam int CMC_PIN_W = 13;
  typedef enum logic [1:0] {
    CMC_IDLE,
    CMC_ISSUE,
    CMC_FOLD,
    CMC_FINISH
  } cmc_state_t;
endpackage

// File: design/cmc_mem_if.sv
// port bundle between the checker and its configuration memory
`timescale 1ns/1ps
`default_nettype none
interface cmc_mem_if;
  logic wr_en;
  logic rd_en;
  logic [cmc_pkg::CMC_AW-1:0] addr;
  logic [cmc_pkg::CMC_DW-1:0] wdata;
  logic [cmc_pkg::CMC_DW-1:0] rdata;
  modport ctrl (output wr_en, output rd_en, output addr, output wdata, input rdata);
  modport mem (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// File: design/cmc_cfg_mem.sv
// configuration cell array with registered read data
`timescale 1ns/1ps
`default_nettype none
module cmc_cfg_mem (
  input wire logic clk_in,
  input wire logic nrst_in,
  cmc_mem_if.mem port
);
  logic [cmc_pkg::CMC_DW-1:0] cells [cmc_pkg::CMC_DEPTH];
  logic [cmc_pkg::CMC_DW-1:0] rdata_q;

  always_ff @(posedge clk_in) begin
    if (port.wr_en) begin
      cells[port.addr] <= port.wdata;
    end
  end

  // a write owns the port, so a read in the same cycle is never issued
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_q <= '0;
    end else if (port.rd_en) begin
      rdata_q <= cells[port.addr];
    end
  end

  assign port.rdata = rdata_q;
endmodule
`default_nettype wire

// File: design/cmc_frame_crc.sv
// per-frame 16-bit crc check during configuration loading
`timescale 1ns/1ps
`default_nettype none
module cmc_frame_crc (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic word_valid_in,
  input wire logic [31:0] word_in,
  input wire logic frame_end_in,
  input wire logic [15:0] frame_crc_in,
  output logic mismatch_out
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic mismatch_q;
  logic bad_frame;

  function automatic logic [15:0] cmc_crc16(input logic [15:0] c, input logic [31:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ cmc_pkg::CMC_CRC16_POLY;
      end
    end
    return r;
  endfunction

  // the expected value arrives while the last word may still be folding
  assign crc_d = word_valid_in ? cmc_crc16(crc_q, word_in) : crc_q;
  assign bad_frame = frame_end_in && (crc_d != frame_crc_in);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      crc_q <= cmc_pkg::CMC_CRC16_INIT;
      mismatch_q <= 1'b0;
    end else begin
      crc_q <= frame_end_in ? cmc_pkg::CMC_CRC16_INIT : crc_d;
      mismatch_q <= bad_frame;
    end
  end

  assign mismatch_out = mismatch_q;

  a_frame_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
    frame_end_in && (crc_d != frame_crc_in) |=> mismatch_out)
    else $error("frame crc mismatch not flagged");
endmodule
`default_nettype wire

// File: design/cmc_checker.sv
// user-mode configuration memory crc checker with scan-loaded expected value
`timescale 1ns/1ps
`default_nettype none
module cmc_checker (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic cfg_wr_in,
  input wire logic [cmc_pkg::CMC_AW-1:0] cfg_addr_in,
  input wire logic [31:0] cfg_data_in,
  input wire logic cfg_frame_end_in,
  input wire logic [15:0] cfg_frame_crc_in,
  input wire logic cfg_done_in,
  input wire logic [31:0] cfg_expected_crc_in,
  input wire logic init_done_in,
  input wire logic check_enable_in,
  input wire logic [3:0] div_exp_in,
  input wire logic tck_in,
  input wire logic tdi_in,
  input wire logic shift_dr_in,
  input wire logic [cmc_pkg::CMC_IR_W-1:0] instr_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  output logic crc_error_out,
  output logic [31:0] signature_out,
  output logic pass_done_out,
  output logic checking_out,
  output logic cfg_status_n_out
);
  cmc_mem_if mif ();

  cmc_cfg_mem u_mem (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .port(mif.mem)
  );

  logic frame_bad;
  logic frame_word;

  cmc_frame_crc u_frame (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .word_valid_in(frame_word),
    .word_in(cfg_data_in),
    .frame_end_in(cfg_frame_end_in),
    .frame_crc_in(cfg_frame_crc_in),
    .mismatch_out(frame_bad)
  );

  // test port pins arrive asynchronously: three stages, and a new
  // value is accepted only once stages two and three agree
  logic [cmc_pkg::CMC_PIN_W-1:0] pin_raw;
  logic [cmc_pkg::CMC_PIN_W-1:0] s1_q;
  logic [cmc_pkg::CMC_PIN_W-1:0] s2_q;
  logic [cmc_pkg::CMC_PIN_W-1:0] s3_q;
  logic [cmc_pkg::CMC_PIN_W-1:0] pin_q;

  assign pin_raw = {instr_in, shift_dr_in, tdi_in, tck_in};

  generate
    for (genvar g = 0; g < cmc_pkg::CMC_PIN_W; g++) begin : g_sync
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          pin_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            pin_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  // storage register and its scan chain
  logic tck_prev_q;
  logic tck_rise;
  logic scan_sel;
  logic scan_shift;
  logic done_prev_q;
  logic cfg_rise;
  logic [31:0] storage_q;
  logic [31:0] storage_d;
  logic tdo_q;
  logic tdo_oe_q;
  logic status_n_q;

  assign tck_rise = pin_q[cmc_pkg::CMC_PIN_TCK] && !tck_prev_q;
  assign scan_sel = pin_q[cmc_pkg::CMC_PIN_IR +: cmc_pkg::CMC_IR_W] == cmc_pkg::CMC_SCAN_INSTR;
  assign scan_shift = scan_sel && pin_q[cmc_pkg::CMC_PIN_SHIFT] && tck_rise;
  assign cfg_rise = cfg_done_in && !done_prev_q;
  assign frame_word = cfg_wr_in && !cfg_done_in;

  // the chain shifts lsb first toward tdo; the checker keeps running
  // because it only samples storage at the start of each pass
  assign storage_d = cfg_rise ? cfg_expected_crc_in :
                     scan_shift ? {pin_q[cmc_pkg::CMC_PIN_TDI], storage_q[31:1]} :
                     storage_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tck_prev_q <= 1'b0;
      done_prev_q <= 1'b0;
      storage_q <= cmc_pkg::CMC_STORE_RST;
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tck_prev_q <= pin_q[cmc_pkg::CMC_PIN_TCK];
      done_prev_q <= cfg_done_in;
      storage_q <= storage_d;
      tdo_q <= storage_d[0];
      tdo_oe_q <= scan_sel;
    end
  end

  // status stays low once any frame failed, until the next reset
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_n_q <= 1'b1;
    end else if (frame_bad) begin
      status_n_q <= 1'b0;
    end
  end

  // check clock: an 80 MHz tick from the 200 MHz core clock by a
  // fractional accumulator, then divided by two to the n
  cmc_pkg::cmc_state_t state_q;
  cmc_pkg::cmc_state_t state_d;
  logic [18:0] acc_q;
  logic [18:0] acc_sum;
  logic base_tick;
  logic [7:0] div_cnt_q;
  logic [7:0] div_mask;
  logic [3:0] div_exp_q;
  logic [3:0] div_exp_lim;
  logic chk_tick;
  logic tick_pend_q;
  logic running;

  assign running = state_q != cmc_pkg::CMC_IDLE;
  assign acc_sum = acc_q + cmc_pkg::CMC_ACC_STEP;
  assign base_tick = running && (acc_sum >= cmc_pkg::CMC_ACC_WRAP);
  // larger exponents are clamped, keeping the rate at or above the floor
  assign div_exp_lim = (div_exp_in > cmc_pkg::CMC_DIV_EXP_MAX) ? cmc_pkg::CMC_DIV_EXP_MAX : div_exp_in;
  assign div_mask = 8'((9'h001 << div_exp_q) - 9'h001);
  assign chk_tick = base_tick && (div_cnt_q == div_mask);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_q <= '0;
      div_cnt_q <= '0;
    end else if (!running) begin
      acc_q <= '0;
      div_cnt_q <= '0;
    end else if (base_tick) begin
      acc_q <= acc_sum - cmc_pkg::CMC_ACC_WRAP;
      div_cnt_q <= chk_tick ? 8'h00 : div_cnt_q + 8'h01;
    end else begin
      acc_q <= acc_sum;
    end
  end

  // pass sequencer: one memory word folded per check tick
  function automatic logic [31:0] cmc_crc32(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      fb = r[31] ^ d[i];
      r = {r[30:0], 1'b0};
      if (fb) begin
        r = r ^ cmc_pkg::CMC_CRC32_POLY;
      end
    end
    return r;
  endfunction

  logic run_ok;
  logic rd_go;
  logic last_word;
  logic [cmc_pkg::CMC_AW-1:0] addr_q;
  logic [31:0] crc_q;
  logic [31:0] crc_fold;
  logic [31:0] cmp_q;
  logic [31:0] sig_q;
  logic [31:0] sig_new;
  logic err_q;
  logic pass_q;
  logic checking_q;

  assign run_ok = check_enable_in && cfg_done_in && init_done_in;
  // a configuration write owns the memory port; the read waits while cfg_wr_in is high
  assign rd_go = (state_q == cmc_pkg::CMC_ISSUE) && tick_pend_q && !cfg_wr_in;
  assign last_word = addr_q == cmc_pkg::CMC_LAST_ADDR;
  assign crc_fold = cmc_crc32(crc_q, mif.rdata);
  assign sig_new = crc_q ^ cmp_q;

  assign mif.wr_en = cfg_wr_in;
  assign mif.rd_en = rd_go;
  assign mif.addr = cfg_wr_in ? cfg_addr_in : addr_q;
  assign mif.wdata = cfg_data_in;

  always_comb begin
    state_d = state_q;
    case (state_q)
      cmc_pkg::CMC_IDLE: begin
        if (run_ok) begin
          state_d = cmc_pkg::CMC_ISSUE;
        end
      end
      cmc_pkg::CMC_ISSUE: begin
        if (rd_go) begin
          state_d = cmc_pkg::CMC_FOLD;
        end
      end
      cmc_pkg::CMC_FOLD: begin
        state_d = last_word ? cmc_pkg::CMC_FINISH : cmc_pkg::CMC_ISSUE;
      end
      default: begin
        state_d = cmc_pkg::CMC_ISSUE;
      end
    endcase
    if (!run_ok) begin
      state_d = cmc_pkg::CMC_IDLE;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= cmc_pkg::CMC_IDLE;
      tick_pend_q <= 1'b0;
      checking_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tick_pend_q <= chk_tick || (tick_pend_q && !rd_go);
      checking_q <= state_d != cmc_pkg::CMC_IDLE;
    end
  end

  // exponent is sampled once on start and ignored while running
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_exp_q <= 4'h0;
    end else if (state_q == cmc_pkg::CMC_IDLE) begin
      div_exp_q <= div_exp_lim;
    end
  end

  // running crc, address and the compare copy of the storage value
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr_q <= '0;
      crc_q <= cmc_pkg::CMC_CRC32_INIT;
      cmp_q <= cmc_pkg::CMC_STORE_RST;
    end else if (state_q == cmc_pkg::CMC_IDLE || state_q == cmc_pkg::CMC_FINISH) begin
      addr_q <= '0;
      crc_q <= cmc_pkg::CMC_CRC32_INIT;
      cmp_q <= storage_q;
    end else if (state_q == cmc_pkg::CMC_FOLD) begin
      addr_q <= addr_q + 6'h01;
      crc_q <= crc_fold;
    end
  end

  // while run_ok holds, signature and error only change at the end of a pass, so a raised
  // error stands through the whole following pass
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sig_q <= cmc_pkg::CMC_SIG_RST;
      err_q <= 1'b0;
      pass_q <= 1'b0;
    end else if (!run_ok) begin
      sig_q <= cmc_pkg::CMC_SIG_RST;
      err_q <= 1'b0;
      pass_q <= 1'b0;
    end else begin
      pass_q <= state_q == cmc_pkg::CMC_FINISH;
      if (state_q == cmc_pkg::CMC_FINISH) begin
        sig_q <= sig_new;
        err_q <= |sig_new;
      end
    end
  end

  assign tdo_out = tdo_q;
  assign tdo_oe_out = tdo_oe_q;
  assign crc_error_out = err_q;
  assign signature_out = sig_q;
  assign pass_done_out = pass_q;
  assign checking_out = checking_q;
  assign cfg_status_n_out = status_n_q;

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_finish;
    state_q == cmc_pkg::CMC_FINISH && run_ok;
  endsequence

  sequence s_fetch;
    rd_go && run_ok ##1 state_q == cmc_pkg::CMC_FOLD;
  endsequence

  a_err_from_sig: assert property (crc_error_out == (|signature_out))
    else $error("error output disagrees with signature");
  a_err_held: assert property (state_q != cmc_pkg::CMC_FINISH && run_ok |=> $stable(crc_error_out))
    else $error("error output changed inside a pass");
  a_sig_result: assert property (s_finish |=> signature_out == $past(crc_q ^ cmp_q))
    else $error("signature is not crc against expected");
  a_pass_repeat: assert property (s_finish |=> state_q == cmc_pkg::CMC_ISSUE && pass_done_out)
    else $error("pass did not restart");
  a_err_off_idle: assert property (!run_ok |=> !crc_error_out && !checking_out)
    else $error("error output active while not checking");
  a_auto_start: assert property (state_q == cmc_pkg::CMC_IDLE && run_ok |=> state_q == cmc_pkg::CMC_ISSUE)
    else $error("checking did not start");
  a_store_load: assert property ($rose(cfg_done_in) |=> storage_q == $past(cfg_expected_crc_in))
    else $error("storage not loaded at config end");
  a_scan_chain: assert property (scan_shift && !cfg_rise |=>
    storage_q == {$past(pin_q[cmc_pkg::CMC_PIN_TDI]), $past(storage_q[31:1])})
    else $error("storage did not shift one place");
  a_tick_rate: assert property (base_tick |=> !base_tick)
    else $error("check tick above 80 MHz");
  a_fold_walk: assert property (s_fetch |=> state_q != cmc_pkg::CMC_FOLD)
    else $error("fold lasted more than one cycle");
  a_exp_fixed: assert property (running && $past(running) |-> $stable(div_exp_q))
    else $error("divider changed while checking");
  a_status_low: assert property (!cfg_status_n_out |=> !cfg_status_n_out)
    else $error("status released before reset");
endmodule
`default_nettype wire

// File: test/cmc_tap_host.sv
// test-port host model that scans the expected-value chain
`timescale 1ns/1ps
`default_nettype none
module cmc_tap_host (
  input wire logic clk_in,
  input wire logic tdo_in,
  input wire logic tdo_oe_in,
  output logic tck_out,
  output logic tdi_out,
  output logic shift_dr_out,
  output logic [cmc_pkg::CMC_IR_W-1:0] instr_out
);
  // half period well above the pin synchroniser delay
  localparam int HALF = 8;
  initial begin
    tck_out = 1'b0;
    tdi_out = 1'b0;
    shift_dr_out = 1'b0;
    instr_out = 10'h3ff;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // lsb first; oe reports whether the chain drove tdo on every bit
  task automatic scan32(input logic [9:0] ins, input logic [31:0] din, output logic [31:0] dout,
                        output logic oe);
    oe = 1'b1;
    @(posedge clk_in);
    instr_out <= ins;
    shift_dr_out <= 1'b1;
    hold(HALF);
    for (int i = 0; i < 32; i++) begin
      // an undriven tdo reads as garbage, never as the last driven bit
      dout[i] = tdo_oe_in ? tdo_in : ~tdo_in;
      oe = oe & tdo_oe_in;
      tdi_out <= din[i];
      hold(HALF);
      tck_out <= 1'b1;
      hold(HALF);
      tck_out <= 1'b0;
    end
    shift_dr_out <= 1'b0;
    tdi_out <= ~din[31];
    hold(HALF);
    instr_out <= 10'h3ff;
    hold(HALF);
  endtask
endmodule
`default_nettype wire

// File: test/tb_config_memory_crc_checker.sv
// self-checking bench for the configuration memory crc checker
`timescale 1ns/1ps
`default_nettype none
module tb_config_memory_crc_checker;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wr = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] data = 32'h00000000;
  logic fend = 1'b0;
  logic [15:0] fcrc = 16'h0000;
  logic done = 1'b0;
  logic [31:0] expc = 32'h00000000;
  logic initd = 1'b0;
  logic en = 1'b0;
  logic [3:0] dexp = 4'h0;
  logic tck, tdi, sdr, tdo, tdo_oe, err, pdone, chk, stat_n;
  logic [9:0] ins;
  logic [31:0] sig;
  logic [31:0] mem_m [64];
  int n_mismatch = 0;
  int checked = 0;
  always #2.5 clk_in = ~clk_in;
  cmc_checker DUT (.clk_in(clk_in), .nrst_in(nrst_in), .cfg_wr_in(wr), .cfg_addr_in(addr),
    .cfg_data_in(data), .cfg_frame_end_in(fend), .cfg_frame_crc_in(fcrc), .cfg_done_in(done),
    .cfg_expected_crc_in(expc), .init_done_in(initd), .check_enable_in(en), .div_exp_in(dexp),
    .tck_in(tck), .tdi_in(tdi), .shift_dr_in(sdr), .instr_in(ins), .tdo_out(tdo),
    .tdo_oe_out(tdo_oe), .crc_error_out(err), .signature_out(sig), .pass_done_out(pdone),
    .checking_out(chk), .cfg_status_n_out(stat_n));
  cmc_tap_host host (.clk_in(clk_in), .tdo_in(tdo), .tdo_oe_in(tdo_oe), .tck_out(tck),
    .tdi_out(tdi), .shift_dr_out(sdr), .instr_out(ins));
  function automatic logic [15:0] c16w(input logic [15:0] c, input logic [31:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 31; i >= 0; i--)
      r = (r[15] ^ w[i]) ? ((r << 1) ^ cmc_pkg::CMC_CRC16_POLY) : (r << 1);
    return r;
  endfunction
  // reference crc over the whole model image, word 0 first, msb first
  function automatic logic [31:0] img_crc();
    logic [31:0] r;
    r = cmc_pkg::CMC_CRC32_INIT;
    for (int a = 0; a < 64; a++)
      for (int i = 31; i >= 0; i--)
        r = (r[31] ^ mem_m[a][i]) ? ((r << 1) ^ cmc_pkg::CMC_CRC32_POLY) : (r << 1);
    return r;
  endfunction
  task automatic cmp_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_f(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr1(input int a, input logic [31:0] d, input logic fe, input logic [15:0] fc);
    wr <= 1'b1;
    addr <= 6'(a);
    data <= d;
    fend <= fe;
    fcrc <= fc;
    mem_m[a] = d;
    @(posedge clk_in);
  endtask
  // strobe stays up between back-to-back writes; this drops it after the last one
  task automatic wr_idle();
    wr <= 1'b0;
    fend <= 1'b0;
  endtask
  // lows counts cycles with the error output low during the pass
  task automatic wait_pass(output int cyc, output int lows);
    cyc = 0;
    lows = 0;
    do begin
      @(posedge clk_in);
      cyc++;
      if (err !== 1'b1) lows++;
    end while (pdone !== 1'b1 && cyc < 50000);
    if (cyc >= 50000) begin
      n_mismatch++;
      $display("ERROR pass_done expected 1 seen 0");
    end
  endtask
  task automatic passes(input int n);
    int c, l;
    repeat (n) wait_pass(c, l);
  endtask
  initial begin
    #(100000 * 5);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    logic [15:0] c16;
    logic [31:0] w, good, bad, got;
    logic oe;
    int c, l, t[3];
    void'($urandom(52));
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    for (int f = 0; f < 4; f++) begin
      c16 = cmc_pkg::CMC_CRC16_INIT;
      for (int i = 0; i < 16; i++) begin
        w = $urandom;
        c16 = c16w(c16, w);
        wr1(f * 16 + i, w, i == 15, c16);
      end
    end
    wr_idle();
    repeat (3) @(posedge clk_in);
    cmp_f("cfg_status_n", 1'b1, stat_n);
    wr1(63, mem_m[63], 1'b1, c16w(cmc_pkg::CMC_CRC16_INIT, mem_m[63]) ^ 16'h0001);
    wr_idle();
    repeat (3) @(posedge clk_in);
    cmp_f("cfg_status_n", 1'b0, stat_n);
    good = img_crc();
    expc <= good;
    done <= 1'b1;
    en <= 1'b1;
    repeat (20) @(posedge clk_in);
    cmp_f("checking", 1'b0, chk);
    cmp_f("crc_error", 1'b0, err);
    initd <= 1'b1;
    repeat (3) @(posedge clk_in);
    cmp_f("checking", 1'b1, chk);
    wait_pass(c, l);
    cmp_w("signature", 32'h00000000, sig);
    cmp_f("crc_error", 1'b0, err);
    $display("test config and start done");
    bad = good ^ ($urandom | 32'h00000001);
    host.scan32(cmc_pkg::CMC_SCAN_INSTR, bad, got, oe);
    cmp_w("scan out", good, got);
    cmp_f("tdo_oe", 1'b1, oe);
    cmp_f("checking", 1'b1, chk);
    passes(2);
    cmp_w("signature", good ^ bad, sig);
    cmp_f("crc_error", 1'b1, err);
    wait_pass(c, l);
    cmp_w("error low cycles", 32'h00000000, 32'(l));
    host.scan32(10'h000, good, got, oe);
    cmp_f("tdo_oe", 1'b0, oe);
    passes(2);
    cmp_f("crc_error", 1'b1, err);
    host.scan32(cmc_pkg::CMC_SCAN_INSTR, good, got, oe);
    cmp_w("scan out", bad, got);
    passes(2);
    cmp_f("crc_error", 1'b0, err);
    cmp_w("signature", 32'h00000000, sig);
    $display("test scan injection done");
    w = mem_m[17];
    wr1(17, w ^ 32'h00000100, 1'b0, 16'h0000);
    wr_idle();
    passes(2);
    cmp_w("signature", img_crc() ^ good, sig);
    cmp_f("crc_error", 1'b1, err);
    en <= 1'b0;
    repeat (3) @(posedge clk_in);
    cmp_f("checking", 1'b0, chk);
    cmp_f("crc_error", 1'b0, err);
    wr1(17, w, 1'b0, 16'h0000);
    wr_idle();
    $display("test cell upset and disable done");
    for (int n = 0; n < 3; n++) begin
      dexp <= 4'(n);
      en <= 1'b1;
      wait_pass(c, l);
      wait_pass(t[n], l);
      cmp_w("signature", 32'h00000000, sig);
      en <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
    // one tick of slack per pass, since ticks come from a 2-or-3 cycle accumulator
    cmp_f("pass time n1", 1'b1, (t[1] - t[0]) inside {[148:172]});
    cmp_f("pass time n2", 1'b1, (t[2] - t[1]) inside {[300:340]});
    dexp <= 4'h0;
    en <= 1'b1;
    $display("test divider done");
    passes(1);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    cmp_f("checking", 1'b0, chk);
    cmp_f("crc_error", 1'b0, err);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
